// ===== hdl/vsft_top.sv
// vertical pulse, odd/even field and back-porch gate from sliced sync
// assumes sync_i is high while sync is active and synchronous to clk_sys_i
`timescale 1ns/100ps
module vsft_top #(
   parameter int DEFAULT_THR   = vsft_pkg::DEF_DELAY_CYCLES,
   parameter int SERRATION_THR = vsft_pkg::SERR_THR_CYCLES,
   parameter int OSC_PERIOD    = vsft_pkg::OSC_PERIOD_CYCLES,
   parameter int LINE_GAP_THR  = vsft_pkg::LINE_GAP_CYCLES
) (
   // clock and reset
   input  wire logic           clk_sys_i,
   input  wire logic           rst_i,
   // sliced composite sync
   input  wire logic           sync_i,
   // timing outputs
   output vsft_pkg::vsft_out_t timing_o
);
   import vsft_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   typedef logic [CW-1:0] cnt_t;
   localparam cnt_t DEF_T  = cnt_t'(DEFAULT_THR);
   localparam cnt_t SER_T  = cnt_t'(SERRATION_THR);
   localparam cnt_t OSC_T  = cnt_t'(OSC_PERIOD);
   localparam cnt_t GAP_T  = cnt_t'(LINE_GAP_THR);
   localparam cnt_t BP_T   = cnt_t'(BP_CYCLES);
   localparam logic [3:0] OSC_N = 4'(OSC_COUNT);

   logic       sync_q, sync_d;
   cnt_t       act_q, act_d;        // sync-active integrator
   cnt_t       gap_q, gap_d;        // sync-inactive integrator
   logic       def_fired_q, def_fired_d;
   logic       vpulse_q, vpulse_d;
   cnt_t       osc_q, osc_d;
   logic [3:0] div_q, div_d;
   logic       tog_q, tog_d;
   logic       field_q, field_d;
   cnt_t       bp_q, bp_d;
   logic       bp_n_q, bp_n_d;

   logic rise;
   logic fall;
   logic ser_trig;
   logic def_trig;
   logic trig;
   logic start;

   // ****************************************************************
   // sync edges and triggers
   // ****************************************************************
   // edges compare the pin with last cycle's sample; the sample resets
   // to the idle level so no false edge follows reset
   assign rise     = sync_i & ~sync_q;
   assign fall     = ~sync_i & sync_q;

   // end edge of a serration or of a long sync above lower threshold
   assign ser_trig = fall & (act_q >= SER_T);

   // default path fires once per sync interval
   assign def_trig = sync_i & ~def_fired_q & (act_q >= DEF_T);

   // either path alone starts the pulse
   assign trig     = ser_trig | def_trig;

   // a trigger only counts while no pulse runs
   assign start    = trig & ~vpulse_q;

   // ****************************************************************
   // integrators
   // ****************************************************************
   // counters stand in for the charge of the analog integrators
   always_comb begin
      sync_d      = sync_i;
      act_d       = act_q;
      gap_d       = gap_q;
      def_fired_d = def_fired_q;

      // saturate rather than wrap, so a stuck pin cannot retrigger
      if (sync_i) begin
         if (act_q != '1) act_d = act_q + cnt_t'(1);
         gap_d = '0;
      end else begin
         if (gap_q != '1) gap_d = gap_q + cnt_t'(1);
         act_d       = '0;
         def_fired_d = 1'b0;
      end

      if (def_trig) begin
         def_fired_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sync_q      <= 1'b0;
         act_q       <= '0;
         gap_q       <= '0;
         def_fired_q <= 1'b0;
      end else begin
         sync_q      <= sync_d;
         act_q       <= act_d;
         gap_q       <= gap_d;
         def_fired_q <= def_fired_d;
      end
   end

   // ****************************************************************
   // vertical pulse
   // ****************************************************************
   // pulse timer: period counter feeding a divide-by-eight
   always_comb begin
      vpulse_d = vpulse_q;
      osc_d    = osc_q;
      div_d    = div_q;

      if (vpulse_q) begin
         if (osc_q == OSC_T - cnt_t'(1)) begin
            osc_d = '0;
            if (div_q == OSC_N - 4'h1) begin
               vpulse_d = 1'b0;
               div_d    = '0;
            end else begin
               div_d = div_q + 4'h1;
            end
         end else begin
            osc_d = osc_q + cnt_t'(1);
         end
      end

      // a trigger after the pulse ended restarts the timer; a long
      // pulse therefore swallows late triggers
      if (start) begin
         vpulse_d = 1'b1;
         osc_d    = '0;
         div_d    = '0;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         vpulse_q <= 1'b0;
         osc_q    <= '0;
         div_q    <= '0;
      end else begin
         vpulse_q <= vpulse_d;
         osc_q    <= osc_d;
         div_q    <= div_d;
      end
   end

   // ****************************************************************
   // odd/even field
   // ****************************************************************
   always_comb begin
      tog_d   = tog_q;
      field_d = field_q;

      // toggle on each sync leading edge, cleared by a full-line gap
      if (rise) begin
         if (gap_q >= GAP_T) tog_d = 1'b0;
         else tog_d = ~tog_q;
      end

      // latch field polarity as the pulse starts; a start never
      // shares a cycle with a leading edge
      if (start) begin
         field_d = tog_q;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         tog_q   <= 1'b0;
         field_q <= 1'b0;
      end else begin
         tog_q   <= tog_d;
         field_q <= field_d;
      end
   end

   // ****************************************************************
   // back-porch gate
   // ****************************************************************
   // suppressed during the vertical pulse, where serrations would
   // otherwise gate broad sync
   always_comb begin
      bp_d   = bp_q;
      bp_n_d = bp_n_q;

      if (fall && !vpulse_q) begin
         bp_n_d = 1'b0;
         bp_d   = '0;
      end else if (!bp_n_q) begin
         if (bp_q == BP_T - cnt_t'(1)) bp_n_d = 1'b1;
         else bp_d = bp_q + cnt_t'(1);
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         bp_q   <= '0;
         bp_n_q <= 1'b1;
      end else begin
         bp_q   <= bp_d;
         bp_n_q <= bp_n_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************

   assign timing_o.vsync       = vpulse_q;
   assign timing_o.field       = field_q;
   assign timing_o.backporch_n = bp_n_q;
endmodule : vsft_top

// ===== hdl/vsft_pkg.sv
// package of constants and carrier types for the video sync field timing block
// assumes a 10 MHz system clock and a sliced, synchronous sync input
// Contract
// - long unserrated vertical sync still yields a vertical pulse after a delay
// - default pulse starts when sync-active time reaches the default threshold
// - default pulse ending early: sync end above lower threshold retriggers
// - serrated use: default delay set well past serration spacing
// - unserrated use: default delay shorter than vertical sync period
// - lower threshold must be reached before vertical sync ends
// - to avoid a second pulse, pulse length should outlast vertical sync
// - full-line gap reaching threshold clears the field toggle flop
// - half-line gaps stay short, so the toggle flips on each equalizer
// - field output from toggle versus vertical pulse; low even, high odd
// - odd field starts at first equalizer, even at second
// - trailing sync edge outside the vertical pulse drives back-porch output low for 4 us
// - vertical pulse lasts eight oscillator periods, cleared by divide-by-8
// - serration end edge with lower threshold exceeded sets pulse latch
package vsft_pkg;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_FREQ_MHZ      = 10;
   localparam int BP_TIME_US        = 4;
   localparam int BP_CYCLES         = BP_TIME_US * CLK_FREQ_MHZ;
   localparam int SERR_SPACING_US   = 30;
   localparam int DEF_DELAY_US      = 50;
   localparam int DEF_DELAY_CYCLES  = DEF_DELAY_US * CLK_FREQ_MHZ;
   localparam int SERR_THR_US       = 20;
   localparam int SERR_THR_CYCLES   = SERR_THR_US * CLK_FREQ_MHZ;
   localparam int OSC_PERIOD_US     = 22;
   localparam int OSC_PERIOD_CYCLES = OSC_PERIOD_US * CLK_FREQ_MHZ;
   localparam int OSC_COUNT         = 8;
   localparam int LINE_GAP_US       = 45;
   localparam int LINE_GAP_CYCLES   = LINE_GAP_US * CLK_FREQ_MHZ;
   localparam int CW                = 16;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic vsync;
      logic field;
      logic backporch_n;
   } vsft_out_t;

   typedef struct packed {
      logic [CW-1:0] default_thr;
      logic [CW-1:0] serration_thr;
      logic [CW-1:0] osc_period;
      logic [CW-1:0] line_gap_thr;
      logic [CW-1:0] bp_len;
   } vsft_cfg_t;
endpackage : vsft_pkg

// ===== dv/vsft_assertions.sv
// checker of the timing relations seen at the top ports
// assumes a bind from the bench top file
`timescale 1ns/100ps
module vsft_assertions #(
   parameter int DEFAULT_THR   = 50,
   parameter int SERRATION_THR = 20,
   parameter int OSC_PERIOD    = 4,
   parameter int LINE_GAP_THR  = 45
) (
   input wire logic          clk_sys_i,
   input wire logic          rst_i,
   input wire logic          sync_i,
   input vsft_pkg::vsft_out_t timing_o
);
   logic [15:0] act_q, gap_q, bp_q, vs_q;
   logic        tog_q;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         {act_q, gap_q, bp_q, vs_q, tog_q} <= '0;
      end else begin
         act_q <= sync_i ? act_q + 16'h1 : 16'h0;
         gap_q <= sync_i ? 16'h0 : gap_q + 16'h1;
         bp_q  <= timing_o.backporch_n ? 16'h0 : bp_q + 16'h1;
         vs_q  <= timing_o.vsync ? vs_q + 16'h1 : 16'h0;
         if (sync_i && gap_q != 16'h0) begin
            tog_q <= (gap_q >= LINE_GAP_THR) ? 1'b0 : ~tog_q;
         end
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // short sync end outside a vertical pulse
   sequence s_hs_end;
      $fell(sync_i) && act_q < SERRATION_THR && !timing_o.vsync
         && timing_o.backporch_n;
   endsequence
   a_bp_start: assert property (s_hs_end |-> ##[1:2] !timing_o.backporch_n)
      else $error("back porch gate did not start");
   a_bp_len: assert property ($rose(timing_o.backporch_n) |->
      bp_q == vsft_pkg::BP_CYCLES) else $error("back porch length wrong");
   a_bp_cause: assert property ($fell(timing_o.backporch_n) |->
      !$past(sync_i) && ($past(sync_i, 2) || $past(sync_i, 3)))
      else $error("back porch gate without sync end");
   a_vs_len: assert property ($fell(timing_o.vsync) |->
      vs_q == 8 * OSC_PERIOD) else $error("vertical pulse length wrong");
   a_vs_serr: assert property ($fell(sync_i) && act_q >= SERRATION_THR
      && !timing_o.vsync |-> ##[1:2] timing_o.vsync)
      else $error("sync end did not start vertical pulse");
   a_vs_def: assert property (sync_i && act_q == DEFAULT_THR
      && !timing_o.vsync |-> ##[0:2] timing_o.vsync)
      else $error("default vertical pulse missing");
   a_field_hold: assert property (!$rose(timing_o.vsync) |->
      $stable(timing_o.field)) else $error("field changed outside pulse");
   a_field_val: assert property ($rose(timing_o.vsync) |->
      timing_o.field == tog_q) else $error("field index wrong");
endmodule : vsft_assertions

// ===== dv/vsft_src.sv
// sync source model: sliced sync pulses on request
// assumes one caller at a time
`timescale 1ns/100ps
module vsft_src (
   input  wire logic clk_sys_i,
   output logic      sync_o
);
   initial sync_o = 1'b0;
   task automatic pulse(input int hi, input int lo);
      @(posedge clk_sys_i) sync_o <= 1'b1;
      repeat (hi) @(posedge clk_sys_i);
      sync_o <= 1'b0;
      repeat (lo) @(posedge clk_sys_i);
   endtask : pulse
endmodule : vsft_src

// ===== dv/vsft_top_tb.sv
// bench: sync through the source model, outputs checked here
// assumes shortened thresholds on the top instance
`timescale 1ns/100ps
module vsft_top_tb;
   import vsft_pkg::*;
   logic      clk_sys_i = 1'b0;
   logic      rst_i     = 1'b1;
   logic      sync;
   vsft_out_t timing;
   int        bad_count = 0;
   int        compares  = 0;
   int        rises     = 0;
   always #50 clk_sys_i = ~clk_sys_i;
   always @(posedge timing.vsync) rises++;
   vsft_src src (.clk_sys_i(clk_sys_i), .sync_o(sync));
   vsft_top #(.DEFAULT_THR(50), .SERRATION_THR(20), .OSC_PERIOD(4),
      .LINE_GAP_THR(45)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .sync_i(sync), .timing_o(timing));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : step
   task automatic t_bp();
      fork
         src.pulse(5, 60);
         begin
            step(8);
            chk(timing.backporch_n, 1'b0);
            step(30);
            chk(timing.backporch_n, 1'b0);
            step(12);
            chk(timing.backporch_n, 1'b1);
         end
      join
   endtask : t_bp
   task automatic t_serr();
      fork
         src.pulse(30, 60);
         begin
            step(33);
            chk(timing.vsync, 1'b1);
            step(18);
            chk(timing.vsync, 1'b1);
            step(20);
            chk(timing.vsync, 1'b0);
         end
      join
   endtask : t_serr
   task automatic t_def(input int hi, input int exp);
      rises = 0;
      fork
         src.pulse(hi, 60);
         begin
            step(56);
            chk(timing.vsync, 1'b1);
         end
      join
      chk(rises[15:0], exp[15:0]);
   endtask : t_def
   task automatic t_field(input int n, input logic exp);
      repeat (2) src.pulse(5, 60);
      repeat (n) src.pulse(3, 40);
      src.pulse(30, 60);
      chk(timing.field, exp);
   endtask : t_field
   task automatic close_out();
      $display("mismatches %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   initial begin
      repeat (10) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      step(5);
      t_bp();
      t_serr();
      t_def(120, 2);
      t_def(70, 1);
      t_field(6, 1'b0);
      t_field(5, 1'b1);
      close_out();
   end
   // far beyond the roughly 1400 cycles the tests take
   initial begin
      #1000000;
      bad_count++;
      close_out();
   end
endmodule : vsft_top_tb
bind vsft_top vsft_assertions #(.DEFAULT_THR(DEFAULT_THR),
   .SERRATION_THR(SERRATION_THR), .OSC_PERIOD(OSC_PERIOD),
   .LINE_GAP_THR(LINE_GAP_THR)) u_chk (.clk_sys_i(clk_sys_i),
   .rst_i(rst_i), .sync_i(sync_i), .timing_o(timing_o));
